// *** rtl/dsw_defines.svh ***
// Purpose: Shared constants for the serial converter write link.
// Assumes: Frame sent first bit first, 24 bits to a frame.
// Notes: Times are in ns; cycle counts are derived from the 20 MHz clock.
`ifndef DSW_DEFINES_SVH
`define DSW_DEFINES_SVH

`define DSW_FRAME_BITS 24
`define DSW_CODE_MSB 15
`define DSW_MODE_LSB 16
`define DSW_MODE_MSB 17
`define DSW_CODE_RESET 16'h0000
`define DSW_LEN_RESET 5'h18

`define DSW_CLK_NS 50
`define DSW_T_SYNC_HIGH_NS 50
`define DSW_T_LAST_TO_SYNC_NS 50
`define DSW_T_WAKE_NS 5000
`define DSW_GAP_CYC ((`DSW_T_SYNC_HIGH_NS + `DSW_CLK_NS - 1) / `DSW_CLK_NS)
`define DSW_WAKE_CYC ((`DSW_T_WAKE_NS + `DSW_CLK_NS - 1) / `DSW_CLK_NS)

`define DSW_ADR_FRAME 4'h0
`define DSW_ADR_CTRL 4'h4
`define DSW_ADR_STATUS 4'h8

`endif

// *** rtl/dsw_pkg.sv ***
// Purpose: Types and helpers for the two ends of the write link; each item serves one end only.
// Assumes: Mode encoding follows the two mode bits of the frame.
// Notes: Enum order gives the mode codes 00, 01, 10, 11.
package dsw_pkg;

  typedef enum logic [1:0] {
    dsw_normal,
    dsw_pd_1k,
    dsw_pd_100k,
    dsw_pd_hiz
  } dsw_mode_t;

  typedef enum logic [1:0] {
    hs_idle,
    hs_high,
    hs_low,
    hs_gap
  } dsw_host_state_t;

  function automatic dsw_mode_t bits_to_mode(input logic [1:0] b);
    return dsw_mode_t'(b);
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

endpackage

// *** rtl/dsw_link_if.sv ***
// Purpose: Three-wire write link between host and converter front end.
// Assumes: The host makes the serial clock.
// Notes: All wires are one-way, so no enables are needed.
interface dsw_link_if;
  logic sync_n;
  logic sclk;
  logic din;

  modport host (
    output sync_n,
    output sclk,
    output din
  );

  modport dev (
    input sync_n,
    input sclk,
    input din
  );
endinterface

// *** rtl/dsw_timer.sv ***
// Purpose: Down-counter that reports when a loaded wait has run out.
// Assumes: Load is a one-cycle pulse on clk.
// Notes: Done is high from reset and whenever the count is zero.
module dsw_timer (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [7:0] count,
  output logic done
);
  logic [7:0] count_r, count_nxt;
  logic done_r, done_nxt;

  always_comb begin
    count_nxt = count_r;
    if (load) begin
      count_nxt = count;
    end else if (count_r != 8'h00) begin
      count_nxt = count_r - 8'h01;
    end
    done_nxt = (count_nxt == 8'h00);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= 8'h00;
      done_r <= 1'b1;
    end else begin
      count_r <= count_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
endmodule // dsw_timer

// *** rtl/dsw_dev.sv ***
// Purpose: Converter front end: frame capture, code register and mode control.
// Assumes: Link logic runs on the falling serial clock; clk is the system side.
// Notes: Frame sync high clears the frame logic at once, with or without a clock.
// Notes: The system copies lag a load by a few clk cycles; software must allow
// for that before it trusts sys_code, sys_mode or output_valid.
//
// Operation
// [R1] 24-bit frame: six ignored, two mode, sixteen data.
// [R2] 24th falling edge loads sixteen data bits.
// [R3] Mode bits pick normal, 1k, 100k or open.
// [R4] Power-down leaves the converter register untouched; the code here loads the data bits of every full frame, power-down frames too.
// [R5] Power-down disables amplifier, switches output network.
// [R6] Output invalid until power-down exit time passes.
// [R7] Power-up clears register, output zero until write.
// [R8] Code is unsigned straight binary, full scale 65536.
// [R9] Host keeps serial clock at most 30 MHz.
// [R10] Host holds sync high at least 50 ns.
// [R11] 50 ns from 24th edge to next sync.
// [R12] Host may raise sync at 24th edge.
// [R13] Sync low starts frame; sample falling edges, MSB first.
// [R14] Early sync rise discards frame and clears shifter.
// [R15] Mode change takes effect with the data load.
// [R16] Ignore clock edges after 24th until new frame.
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`include "dsw_defines.svh"
module dsw_dev (
  dsw_link_if.dev lnk,
  input wire logic clk,
  input wire logic arst_n,
  output logic [15:0] converter_code,
  output dsw_pkg::dsw_mode_t power_mode,
  output logic amp_enable,
  output logic pull_1k,
  output logic pull_100k,
  output logic out_open,
  output logic code_loaded,
  output logic [15:0] sys_code,
  output dsw_pkg::dsw_mode_t sys_mode,
  output logic output_valid
);

  // Field pickers keep the frame layout in one place for both load paths.
  function automatic logic [15:0] code_of(input logic [23:0] f);
    return f[`DSW_CODE_MSB:0];
  endfunction

  function automatic dsw_pkg::dsw_mode_t mode_of(input logic [23:0] f);
    return dsw_pkg::bits_to_mode(f[`DSW_MODE_MSB:`DSW_MODE_LSB]);
  endfunction

  // One decoder drives all four switches, so two networks never close at once.
  function automatic logic [3:0] net_of(input dsw_pkg::dsw_mode_t m);
    logic [3:0] n;
    n = 4'h0;
    unique case (m)
      dsw_pkg::dsw_normal: n = 4'h8;
      dsw_pkg::dsw_pd_1k: n = 4'h4;
      dsw_pkg::dsw_pd_100k: n = 4'h2;
      dsw_pkg::dsw_pd_hiz: n = 4'h1;
    endcase
    return n;
  endfunction

  // Link domain: frame shifter and bit counter.
  logic [22:0] shift_r, shift_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [23:0] frame;
  logic fire;

  always_comb begin
    // The last bit is taken straight from the pin so that the load needs no
    // extra edge after the 24th fall.
    frame = {shift_r, lnk.din}; // [R1] [R13]
    fire = !lnk.sync_n && (cnt_r == 5'(`DSW_FRAME_BITS - 1)); // [R2]
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    // The counter stops at the full length, so late edges change nothing.
    if (cnt_r < 5'(`DSW_FRAME_BITS)) begin // [R16]
      shift_nxt = frame[22:0];
      cnt_nxt = cnt_r + 5'h01;
    end
  end

  // Sync high acts as a clear because the serial clock may never tick again.
  always_ff @(negedge lnk.sclk or negedge arst_n or posedge lnk.sync_n) begin
    if (!arst_n) begin
      shift_r <= 23'h000000;
      cnt_r <= 5'h00;
    end else if (lnk.sync_n) begin
      shift_r <= 23'h000000; // [R14]
      cnt_r <= 5'h00; // [R16]
    end else begin
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Link domain: converter register, mode and output network.
  logic [15:0] code_r, code_nxt;
  dsw_pkg::dsw_mode_t mode_r, mode_nxt;
  logic amp_r, amp_nxt;
  logic p1k_r, p1k_nxt;
  logic p100k_r, p100k_nxt;
  logic open_r, open_nxt;
  logic loaded_r, loaded_nxt;
  logic tog_r, tog_nxt;

  always_comb begin
    code_nxt = code_r;
    mode_nxt = mode_r;
    loaded_nxt = loaded_r;
    tog_nxt = tog_r;
    if (fire) begin
      // Code and mode change on one edge as a single operation.
      code_nxt = code_of(frame); // [R2] [R8] [R4]
      mode_nxt = mode_of(frame); // [R3] [R15]
      loaded_nxt = 1'b1;
      tog_nxt = !tog_r;
    end
    {amp_nxt, p1k_nxt, p100k_nxt, open_nxt} = net_of(mode_nxt); // [R3] [R5]
  end

  always_ff @(negedge lnk.sclk or negedge arst_n) begin
    if (!arst_n) begin
      code_r <= `DSW_CODE_RESET; // [R7]
      mode_r <= dsw_pkg::dsw_normal;
      amp_r <= 1'b1;
      p1k_r <= 1'b0;
      p100k_r <= 1'b0;
      open_r <= 1'b0;
      loaded_r <= 1'b0; // [R7]
      tog_r <= 1'b0;
    end else begin
      code_r <= code_nxt;
      mode_r <= mode_nxt;
      amp_r <= amp_nxt;
      p1k_r <= p1k_nxt;
      p100k_r <= p100k_nxt;
      open_r <= open_nxt;
      loaded_r <= loaded_nxt;
      tog_r <= tog_nxt;
    end
  end

  // The switch controls are registered with the code, so the network never
  // changes between two serial clock edges.
  assign converter_code = code_r;
  assign power_mode = mode_r;
  assign amp_enable = amp_r;
  assign pull_1k = p1k_r;
  assign pull_100k = p100k_r;
  assign out_open = open_r;
  assign code_loaded = loaded_r;

  // System domain: the load toggle crosses in two flip-flops; code and mode
  // stay still for a whole frame after a load, so they are sampled on the
  // detected change without a synchroniser of their own.
  logic tog_s1_r, tog_s2_r, tog_s3_r;
  logic [15:0] scode_r, scode_nxt;
  dsw_pkg::dsw_mode_t smode_r, smode_nxt;
  logic valid_r, valid_nxt;
  logic upd;
  logic wake_load;
  logic wake_done;

  always_comb begin
    upd = tog_s2_r ^ tog_s3_r;
    scode_nxt = scode_r;
    smode_nxt = smode_r;
    wake_load = 1'b0;
    if (upd) begin
      scode_nxt = code_r;
      smode_nxt = mode_r;
      // Only a return to normal from power-down costs the wake-up time.
      wake_load = (mode_r == dsw_pkg::dsw_normal) &&
                  (smode_r != dsw_pkg::dsw_normal); // [R6]
    end
    valid_nxt = (smode_nxt == dsw_pkg::dsw_normal) && wake_done && !wake_load; // [R6]
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
      scode_r <= `DSW_CODE_RESET;
      smode_r <= dsw_pkg::dsw_normal;
      valid_r <= 1'b1;
    end else begin
      tog_s1_r <= tog_r;
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
      scode_r <= scode_nxt;
      smode_r <= smode_nxt;
      valid_r <= valid_nxt;
    end
  end

  // The wait uses the longer supply figure, so it is safe at either supply.
  // A lower count would shorten the invalid window at the cost of that margin.
  dsw_timer u_wake (
    .clk(clk),
    .arst_n(arst_n),
    .load(wake_load),
    .count(8'(`DSW_WAKE_CYC)),
    .done(wake_done)
  );

  assign sys_code = scode_r;
  assign sys_mode = smode_r;
  assign output_valid = valid_r;
endmodule // dsw_dev

// *** rtl/dsw_host.sv ***
// Purpose: Wishbone-driven host that sends frames over the three-wire link.
// Assumes: Serial clock is made from clk by a divide-by-two.
// Notes: A frame write while a frame is in flight is dropped.
`include "dsw_defines.svh"
module dsw_host (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [3:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  dsw_link_if.host lnk
);
  dsw_pkg::dsw_host_state_t st_r, st_nxt;
  logic [17:0] frame_r, frame_nxt;
  logic [4:0] len_r, len_nxt;
  logic [23:0] sh_r, sh_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic sync_n_r, sync_n_nxt;
  logic sclk_r, sclk_nxt;
  logic din_r, din_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [31:0] merged;
  logic [23:0] frame24;
  logic [4:0] last_bit;
  logic wr_ok;
  logic gap_load;
  logic gap_done;

  always_comb begin
    // A write takes effect at the edge where the master sees ack.
    wr_ok = wb_cyc && wb_stb && wb_we && ack_r;
    ack_nxt = wb_cyc && wb_stb && !ack_r;
    rd_nxt = rd_r;
    if (ack_nxt) begin
      case (wb_adr)
        `DSW_ADR_FRAME: rd_nxt = {14'h0000, frame_r};
        `DSW_ADR_CTRL: rd_nxt = {27'h0000000, len_r};
        `DSW_ADR_STATUS: rd_nxt = {28'h0000000, frame_r[17:16], 1'b0, st_r != dsw_pkg::hs_idle};
        default: rd_nxt = 32'h00000000;
      endcase
    end
    last_bit = (len_r == 5'h00 || len_r > 5'(`DSW_FRAME_BITS)) ?
               5'(`DSW_FRAME_BITS - 1) : len_r - 5'h01;
    merged = dsw_pkg::lane_merge({14'h0000, frame_r}, wb_dat_w, wb_sel);
    frame24 = {6'h00, merged[17:0]};
    frame_nxt = frame_r;
    len_nxt = len_r;
    st_nxt = st_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    sync_n_nxt = sync_n_r;
    sclk_nxt = sclk_r;
    din_nxt = din_r;
    gap_load = 1'b0;
    if (wr_ok && wb_adr == `DSW_ADR_CTRL) begin
      len_nxt = 5'(dsw_pkg::lane_merge({27'h0000000, len_r}, wb_dat_w, wb_sel));
    end
    unique case (st_r)
      dsw_pkg::hs_idle: begin
        if (wr_ok && wb_adr == `DSW_ADR_FRAME) begin
          frame_nxt = merged[17:0];
          sync_n_nxt = 1'b0; // [R13]
          din_nxt = frame24[23];
          sh_nxt = {frame24[22:0], 1'b0};
          cnt_nxt = 5'h00;
          st_nxt = dsw_pkg::hs_high;
        end
      end
      dsw_pkg::hs_high: begin
        // Divide-by-two keeps the serial clock at 10 MHz, far below the limit.
        sclk_nxt = 1'b0; // [R9]
        st_nxt = dsw_pkg::hs_low;
      end
      dsw_pkg::hs_low: begin
        sclk_nxt = 1'b1;
        if (cnt_r == last_bit) begin
          // Sync rises right after the last falling edge; a short length
          // cuts the frame off to exercise the early-rise discard.
          sync_n_nxt = 1'b1; // [R12] [R14]
          gap_load = 1'b1;
          st_nxt = dsw_pkg::hs_gap;
        end else begin
          din_nxt = sh_r[23]; // [R13]
          sh_nxt = {sh_r[22:0], 1'b0};
          cnt_nxt = cnt_r + 5'h01;
          st_nxt = dsw_pkg::hs_high;
        end
      end
      dsw_pkg::hs_gap: begin
        if (gap_done) begin // [R10] [R11]
          st_nxt = dsw_pkg::hs_idle;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= dsw_pkg::hs_idle;
      frame_r <= 18'h00000;
      len_r <= `DSW_LEN_RESET;
      sh_r <= 24'h000000;
      cnt_r <= 5'h00;
      sync_n_r <= 1'b1;
      sclk_r <= 1'b1;
      din_r <= 1'b0;
      ack_r <= 1'b0;
      rd_r <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
      frame_r <= frame_nxt;
      len_r <= len_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      sync_n_r <= sync_n_nxt;
      sclk_r <= sclk_nxt;
      din_r <= din_nxt;
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
    end
  end

  dsw_timer u_gap (
    .clk(clk),
    .arst_n(arst_n),
    .load(gap_load),
    .count(8'(`DSW_GAP_CYC)),
    .done(gap_done)
  );

  assign wb_ack = ack_r;
  assign wb_dat_r = rd_r;
  assign lnk.sync_n = sync_n_r;
  assign lnk.sclk = sclk_r;
  assign lnk.din = din_r;
endmodule // dsw_host

// *** tb/dsw_link_monitor.sv ***
// Purpose: Rule checker for the three-wire write link.
// Assumes: All link wires launch from host flops on clk.
// Notes: Serial clock falls are counted per frame in helper logic.
module dsw_link_monitor (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic sclk_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  always_comb begin
    cnt_nxt = sync_n ? 5'h0 : cnt_r + {4'h0, sclk_r & ~sclk};
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 5'h0;
      sclk_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      sclk_r <= sclk;
    end
  end
  AST_FRAME_LEN: assert property ($rose(sync_n) |-> cnt_r inside {[5'h1:5'h18]})
    else $error("frame fall count out of range");
  AST_LOW_ONE: assert property (!sclk |=> sclk)
    else $error("serial clock low too long");
  AST_SYNC_HIGH: assert property ($rose(sync_n) |-> sync_n [*2])
    else $error("sync high time too short");
  AST_LAST_GAP: assert property (cnt_r == 5'h18 |-> sync_n ##1 sync_n)
    else $error("next frame starts too soon");
  AST_SYNC_RISE: assert property ($rose(sync_n) |-> $rose(sclk))
    else $error("sync rose away from frame end");
  AST_DIN_STABLE: assert property ($fell(sclk) |-> $stable(din))
    else $error("data moved at sampling edge");
  AST_START: assert property ($fell(sync_n) |-> sclk ##1 !sclk)
    else $error("bad frame start");
  AST_SCLK_IDLE: assert property (sync_n |-> sclk)
    else $error("serial clock not idle high");
endmodule // dsw_link_monitor

// *** tb/testbench.sv ***
// Purpose: Both ends joined; frames sent by register writes and checked.
// Assumes: Host answers every bus cycle; frames are 24 falls long by default.
// Notes: Power-down frames in the mode loop reuse the live code so the resume code is known.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic arst_n;
  logic wb_cyc, wb_stb, wb_we, wb_ack;
  logic [3:0] wb_adr, wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, rd;
  logic [15:0] converter_code, sys_code, kc;
  dsw_pkg::dsw_mode_t power_mode, sys_mode;
  logic amp_enable, pull_1k, pull_100k, out_open, code_loaded, output_valid;
  logic [17:0] q[$];
  logic [17:0] e;
  int miscompares, samples_checked, nf, cycles;
  integer seed;
  `define CHK(a, x) begin samples_checked++; if ((a) !== (x)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, x); end end
  dsw_link_if lnk();
  dsw_host dsw_host_inst(.clk(clk), .arst_n(arst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .lnk(lnk));
  dsw_dev dsw_dev_inst(.lnk(lnk), .clk(clk), .arst_n(arst_n), .converter_code(converter_code),
    .power_mode(power_mode), .amp_enable(amp_enable), .pull_1k(pull_1k),
    .pull_100k(pull_100k), .out_open(out_open), .code_loaded(code_loaded),
    .sys_code(sys_code), .sys_mode(sys_mode), .output_valid(output_valid));
  dsw_link_monitor dsw_link_monitor_inst(.clk(clk), .arst_n(arst_n), .sync_n(lnk.sync_n),
    .sclk(lnk.sclk), .din(lnk.din));
  task automatic results();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    @(posedge clk);
    while (wb_ack !== 1'b1) begin
      n++;
      @(posedge clk);
    end
    r = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic idle();
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0) begin
      wb(1'b0, 4'h8, 32'h0, rd);
      n++;
    end
  endtask
  task automatic send(input logic [1:0] m, input logic [15:0] c, input bit push);
    wb(1'b1, 4'h0, {14'h0, m, c}, rd);
    if (push) q.push_back({m, c});
    idle();
    repeat (8) @(posedge clk);
    if (push) begin
      `CHK({sys_mode, sys_code}, {m, c})
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end
  always @(posedge lnk.sync_n) nf = 0;
  always @(negedge lnk.sclk) begin
    if (lnk.sync_n === 1'b0) begin
      nf++;
      if (nf == 24) begin
        #1;
        `CHK(q.size() > 0, 1'b1)
        e = q.pop_front();
        `CHK({power_mode, converter_code}, e)
        `CHK({amp_enable, pull_1k, pull_100k, out_open}, 4'h8 >> e[17:16])
        `CHK(code_loaded, 1'b1)
      end
    end
  end
  initial begin
    seed = 32'h96e7;
    arst_n = 1'b0;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} = '0;
    wb_sel = 4'hf;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    `CHK({converter_code, code_loaded, output_valid}, {16'h0, 1'b0, 1'b1})
    wb(1'b0, 4'h4, 32'h0, rd);
    `CHK(rd[4:0], 5'h18)
    wb(1'b0, 4'hc, 32'h0, rd);
    `CHK(rd, 32'h0)
    send(2'h0, 16'hffff, 1);
    send(2'h0, 16'h0000, 1);
    repeat (2) send(2'h0, 16'($random(seed)), 1);
    kc = 16'($random(seed));
    // A write during a frame is acked but dropped, so only the first is expected.
    wb(1'b1, 4'h0, {16'h0, kc}, rd);
    q.push_back({2'h0, kc});
    wb(1'b1, 4'h0, {14'h0, 2'h3, ~kc}, rd);
    idle();
    for (int m = 1; m < 4; m++) begin
      send(2'(m), kc, 1);
      `CHK(output_valid, 1'b0)
      wb(1'b0, 4'h8, 32'h0, rd);
      `CHK(rd[3:2], 2'(m))
    end
    send(2'h0, kc, 1);
    `CHK(output_valid, 1'b0)
    repeat (100) @(posedge clk);
    `CHK(output_valid, 1'b1)
    wb(1'b1, 4'h4, 32'h17, rd);
    send(2'h1, ~kc, 0);
    `CHK({power_mode, converter_code}, {2'h0, kc})
    wb(1'b1, 4'h4, 32'h0, rd);
    send(2'h2, ~kc, 1);
    send(2'h0, ~kc, 1);
    `CHK(q.size(), 0)
    results();
  end
endmodule // testbench
